// file: core/touch_adc_consts.vh
`ifndef TOUCH_ADC_CONSTS_VH
`define TOUCH_ADC_CONSTS_VH

// Register byte offsets on the APB side
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_RESULT      12'h008
`define OFS_COUNT       12'h00c

// Control register fields and reset value
`define CTRL_EN_BIT     0
`define CTRL_RESET      32'h0000_0001

// Status register field positions
`define ST_STATE_LSB    0
`define ST_BUSY_BIT     2
`define ST_ADC_BIT      3
`define ST_REF_BIT      4
`define ST_CS_BIT       5
`define ST_CMD_LSB      8

// Control word field positions
`define CW_START_BIT    7
`define CW_ADDR_MSB     6
`define CW_ADDR_LSB     4
`define CW_MODE_BIT     3
`define CW_DIFF_BIT     2
`define CW_PD_HI_BIT    1
`define CW_PD_LO_BIT    0

// Serial frame lengths in shift clock cycles
`define CMD_LEN         4'd8
`define FRAME12_LEN     5'd16
`define FRAME8_LEN      5'd12

// Power mode after power-on reset
`define PD_RESET        2'b00

`endif

// file: core/pin_sync.v
`timescale 1ns/10ps

// Two-stage synchroniser bank for asynchronous pin inputs
module pin_sync #(
  parameter WIDTH     = 3,
  parameter RESET_VAL = 3'b000
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;   // First stage, read only by the second
  reg [WIDTH-1:0] sync_r;   // Second stage, safe to use

  // Both stages clocked every edge; reset to the idle pin level
  always @(posedge core_clk) begin
    if (rst) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// file: core/apb_regs.v
`timescale 1ns/10ps
`include "touch_adc_consts.vh"

// APB slave holding the control register and presenting status words
module apb_regs (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [31:0] status_word,
  input  wire [31:0] result_word,
  input  wire [31:0] count_word,
  output reg         link_en_r,
  output reg         count_clr_r
);

  localparam [31:0] CTRL_RST_WORD = `CTRL_RESET;  // Control word after reset

  wire setup_c;   // Setup cycle of a transfer
  wire access_c;  // Access cycle, transfer completes here

  assign setup_c  = psel & ~penable;
  assign access_c = psel & penable & pready;

  // Read data and error are prepared in setup so they stand from flops in access
  always @(posedge core_clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_c) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (paddr == `OFS_CTRL) begin
        prdata <= {31'h0000_0000, link_en_r};
      end else if (paddr == `OFS_STATUS) begin
        prdata <= status_word;
      end else if (paddr == `OFS_RESULT) begin
        prdata <= result_word;
      end else if (paddr == `OFS_COUNT) begin
        prdata <= count_word;
      end else begin
        pslverr <= 1'b1;  // Unmapped address
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Writes take effect at the completing edge of the access phase
  always @(posedge core_clk) begin
    if (rst) begin
      link_en_r   <= CTRL_RST_WORD[`CTRL_EN_BIT];
      count_clr_r <= 1'b0;
    end else begin
      count_clr_r <= 1'b0;
      if (access_c && pwrite) begin
        if (paddr == `OFS_CTRL) begin
          link_en_r <= pwdata[`CTRL_EN_BIT];
        end else if (paddr == `OFS_COUNT) begin
          count_clr_r <= 1'b1;  // Any write clears both counters
        end
      end
    end
  end

endmodule

// file: core/touch_adc_serial_readout.v
`timescale 1ns/10ps
`include "touch_adc_consts.vh"

module touch_adc_serial_readout (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        serial_shift_clock,
  input  wire        cs_n,
  input  wire        din,
  output reg         dout,
  output reg         dout_oe,
  output reg         busy,
  input  wire [11:0] adc_sample,
  output reg  [2:0]  channel_addr,
  output reg         diff_mode,
  output reg         adc_power_on,
  output reg         ref_power_on
);

  // Protocol states
  localparam ST_IDLE = 2'd0;  // Waiting for a start bit
  localparam ST_CMD  = 2'd1;  // Shifting in the control word
  localparam ST_ACQ  = 2'd2;  // Acquisition, busy sequence
  localparam ST_DATA = 2'd3;  // Shifting the result out

  wire [2:0]  pins_s;        // Synchronised pin levels
  wire        sclk_s;        // Synchronised shift clock
  wire        cs_n_s;        // Synchronised select, active low
  wire        din_s;         // Synchronised command input
  wire        link_en;       // Interface enable from software
  wire        count_clr;     // Counter clear pulse from software
  wire        cs_act;        // Select low and link enabled
  wire        sclk_rise;     // Rising shift clock edge seen
  wire        sclk_fall;     // Falling shift clock edge seen
  wire        cs_rise;       // Select just went inactive
  wire [7:0]  cmd_word;      // Control word including current bit
  wire [31:0] status_word;   // Status register image
  wire [31:0] result_word;   // Result register image
  wire [31:0] count_word;    // Counter register image
  wire        busy_fall_c;   // Busy about to fall, result sampled now
  wire        frame_end_c;   // Last falling edge of a result frame

  reg         sclk_d_r;      // Shift clock one cycle ago
  reg         cs_act_d_r;    // Select activity one cycle ago
  reg  [1:0]  state_r;       // Protocol state
  reg  [3:0]  cmd_cnt_r;     // Control bits received so far
  reg  [7:0]  cmd_sr_r;      // Control word shift register
  reg  [7:0]  ctrl_byte_r;   // Last accepted control word
  reg  [1:0]  pd_pending_r;  // Power mode to apply after conversion
  reg         mode8_r;       // Eight-bit resolution for this conversion
  reg  [15:0] res_sr_r;      // Result shift register
  reg  [4:0]  bit_cnt_r;     // Result shifts remaining
  reg  [11:0] result_r;      // Last complete result
  reg  [15:0] conv_cnt_r;    // Completed conversions
  reg  [15:0] abort_cnt_r;   // Conversions aborted by select

  // Pin inputs pass two flip-flops; select idles high
  pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'b010)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({din, cs_n, serial_shift_clock}),
    .sync_out (pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign din_s  = pins_s[2];

  // Register bus slave
  apb_regs u_apb_regs (
    .core_clk    (core_clk),
    .rst         (rst),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .status_word (status_word),
    .result_word (result_word),
    .count_word  (count_word),
    .link_en_r   (link_en),
    .count_clr_r (count_clr)
  );

  // Register images built from live state
  assign status_word = {16'h0000, ctrl_byte_r, 2'b00, cs_act, ref_power_on,
                        adc_power_on, busy, state_r};
  assign result_word = {20'h00000, result_r};
  assign count_word  = {abort_cnt_r, conv_cnt_r};

  // Edge detection on synchronised pins
  assign cs_act    = ~cs_n_s & link_en;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign cs_rise   = cs_act_d_r & ~cs_act;
  assign cmd_word  = {cmd_sr_r[6:0], din_s};

  // Conversion milestones used by the result capture and the conversion counter
  assign busy_fall_c = cs_act & (state_r == ST_ACQ) & sclk_fall & busy;
  assign frame_end_c = cs_act & (state_r == ST_DATA) & sclk_fall & (bit_cnt_r == 5'd0);

  // Result as delivered: short mode keeps the upper eight bits, low nibble zero
  function [11:0] trim_sample;
    input [11:0] sample;      // Converter code
    input        short_mode;  // Eight-bit resolution selected
    begin
      if (short_mode) begin
        trim_sample = {sample[11:4], 4'h0};
      end else begin
        trim_sample = sample;
      end
    end
  endfunction

  // Delayed copies for edge detection
  always @(posedge core_clk) begin
    if (rst) begin
      sclk_d_r   <= 1'b0;
      cs_act_d_r <= 1'b0;
    end else begin
      sclk_d_r   <= sclk_s;
      cs_act_d_r <= cs_act;
    end
  end

  // Serial protocol engine
  always @(posedge core_clk) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      cmd_cnt_r    <= 4'd0;
      cmd_sr_r     <= 8'h00;
      ctrl_byte_r  <= 8'h00;
      pd_pending_r <= `PD_RESET;
      mode8_r      <= 1'b0;
      res_sr_r     <= 16'h0000;
      bit_cnt_r    <= 5'd0;
      dout         <= 1'b0;
      dout_oe      <= 1'b0;
      busy         <= 1'b0;
      // Channel and power state start cleared, converter off
      channel_addr <= 3'd0;
      diff_mode    <= 1'b0;
      adc_power_on <= 1'b0;
      ref_power_on <= 1'b0;
    end else if (!cs_act) begin
      // Deselected: ignore input, float output, drop busy
      state_r   <= ST_IDLE;
      dout_oe   <= 1'b0;
      busy      <= 1'b0;
      // A half-received control word is dropped
      cmd_cnt_r <= 4'd0;
      dout      <= 1'b0;
      if (cs_rise) begin
        // ADC off at once, reference left as it was
        adc_power_on <= 1'b0;
      end
    end else begin
      // Selected and enabled: drive the result line
      dout_oe <= 1'b1;
      case (state_r)
        ST_IDLE: begin
          // First one on the input opens a control word
          if (sclk_rise && din_s) begin
            state_r   <= ST_CMD;
            cmd_sr_r  <= 8'h01;
            cmd_cnt_r <= 4'd1;
          end
          // Zeros shift out until a result exists
          if (sclk_fall) begin
            dout <= 1'b0;
          end
        end
        ST_CMD: begin
          // Collect the remaining control bits on rising edges
          if (sclk_rise) begin
            cmd_sr_r  <= cmd_word;
            cmd_cnt_r <= cmd_cnt_r + 4'd1;
            if (cmd_cnt_r == `CMD_LEN - 4'd1) begin
              // Full word in: it is the conversion command
              state_r      <= ST_ACQ;
              ctrl_byte_r  <= cmd_word;
              channel_addr <= cmd_word[`CW_ADDR_MSB:`CW_ADDR_LSB];
              diff_mode    <= cmd_word[`CW_DIFF_BIT];
              mode8_r      <= cmd_word[`CW_MODE_BIT];
              pd_pending_r <= {cmd_word[`CW_PD_HI_BIT], cmd_word[`CW_PD_LO_BIT]};
              adc_power_on <= 1'b1;
              ref_power_on <= 1'b1;
            end
          end
          if (sclk_fall) begin
            dout <= 1'b0;
          end
        end
        ST_ACQ: begin
          // Edge driven only, so a slow or halted clock just lengthens it
          if (sclk_fall) begin
            if (!busy) begin
              busy <= 1'b1;
            end else begin
              // Busy falls as the MSB appears on the output
              busy      <= 1'b0;
              state_r   <= ST_DATA;
              dout      <= adc_sample[11];
              if (mode8_r) begin
                // Eight bits then four zeros, four cycles shorter
                res_sr_r  <= {trim_sample(adc_sample, 1'b1), 4'h0};
                bit_cnt_r <= `FRAME8_LEN - 5'd1;
              end else begin
                // Twelve bits then four trailing zeros
                res_sr_r  <= {adc_sample, 4'h0};
                bit_cnt_r <= `FRAME12_LEN - 5'd1;
              end
            end
          end
        end
        ST_DATA: begin
          // One bit per falling edge, no gap at byte boundaries
          if (sclk_fall) begin
            if (bit_cnt_r != 5'd0) begin
              // Next result bit from the shift register
              res_sr_r  <= {res_sr_r[14:0], 1'b0};
              dout      <= res_sr_r[14];
              bit_cnt_r <= bit_cnt_r - 5'd1;
            end else begin
              // Frame done: apply the requested power mode
              state_r      <= ST_IDLE;
              dout         <= 1'b0;
              ref_power_on <= pd_pending_r[1];
              adc_power_on <= pd_pending_r[0];
            end
          end
        end
        default: begin
          // Unused code: recover to idle
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Last result and event counters for software
  always @(posedge core_clk) begin
    if (rst) begin
      result_r    <= 12'h000;
      conv_cnt_r  <= 16'h0000;
      abort_cnt_r <= 16'h0000;
    end else begin
      // Capture the sample at the busy fall
      if (busy_fall_c) begin
        result_r <= trim_sample(adc_sample, mode8_r);
      end
      // Software clear wins over a same-cycle count
      if (count_clr) begin
        conv_cnt_r  <= 16'h0000;
        abort_cnt_r <= 16'h0000;
      end else begin
        // Completion is the last falling edge of the frame
        if (frame_end_c) begin
          conv_cnt_r <= conv_cnt_r + 16'h0001;
        end
        // Aborted means deselected mid command, acquisition or output
        if (cs_rise && state_r != ST_IDLE) begin
          abort_cnt_r <= abort_cnt_r + 16'h0001;
        end
      end
    end
  end

endmodule

// file: test/touch_adc_sva.sv
`timescale 1ns/10ps
// Checks the APB handshake and the serial pins of the readout block
module touch_adc_sva (
  input logic        core_clk,
  input logic        rst,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        serial_shift_clock,
  input logic        cs_n,
  input logic        dout,
  input logic        dout_oe,
  input logic        busy,
  input logic        adc_power_on,
  input logic        ref_power_on
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // APB setup cycle
  sequence setup_s;
    psel && !penable;
  endsequence
  // Select high long enough to have crossed the pin synchroniser
  sequence desel_s;
    cs_n [*5];
  endsequence
  pready_one_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  pready_only_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  unmapped_err_a: assert property ((setup_s ##0 paddr[11:4] != 8'h00) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property ((setup_s ##0 paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00) |=> !pslverr)
    else $error("mapped access refused");
  oe_float_a: assert property (desel_s |-> !dout_oe && !busy)
    else $error("output driven while deselected");
  abort_power_a: assert property (desel_s |-> !adc_power_on)
    else $error("converter powered while deselected");
  ref_keep_a: assert property (desel_s |=> $stable(ref_power_on))
    else $error("reference changed while deselected");
  dout_fall_a: assert property ($changed(dout) |-> !$past(serial_shift_clock))
    else $error("result changed after a rising clock");
  busy_hold_a: assert property ($rose(busy) |-> (busy || cs_n) [*6])
    else $error("busy pulse too short");
  busy_out_a: assert property ($fell(busy) && !cs_n |-> dout_oe)
    else $error("no result driven at busy fall");
  sel_only_a: assert property (dout_oe || busy |-> !$past(cs_n, 3))
    else $error("activity without select");
endmodule
bind touch_adc_serial_readout touch_adc_sva u_sva (.core_clk, .rst, .psel, .penable, .paddr, .prdata, .pready,
  .pslverr, .serial_shift_clock, .cs_n, .dout, .dout_oe, .busy, .adc_power_on, .ref_power_on);

// file: test/host_port.sv
`timescale 1ns/10ps
// Host serial port model: clock idles low, select framed
module host_port (
  input  wire  core_clk,
  input  wire  dout_line,
  output logic serial_shift_clock,
  output logic cs_n,
  output logic din
);
  initial begin
    serial_shift_clock = 1'b0;
    cs_n = 1'b0 | 1'b1;
    din = 1'b0;
  end
  // Unselected data line keeps changing so stale bits cannot pass
  always @(posedge core_clk) begin
    if (cs_n) din <= ~din;
  end
  // One clock period; result sampled on the rise
  task automatic tick(input int half, output logic b);
    repeat (half) @(posedge core_clk);
    serial_shift_clock <= 1'b1;
    b = dout_line;
    repeat (half) @(posedge core_clk);
    serial_shift_clock <= 1'b0;
  endtask
  // Leading zeros, control word, stalled acquisition, result read
  task automatic frame(input logic [7:0] cw, input int lz, half, stall, nbits, output logic [15:0] rx);
    logic b;
    rx = 16'h0;
    cs_n <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < lz + 8; i++) begin
      din <= (i < lz) ? 1'b0 : cw[lz + 7 - i];
      tick(half, b);
    end
    din <= 1'b0;
    repeat (stall) @(posedge core_clk);
    tick(half, b);
    for (int i = 0; i < nbits; i++) begin
      tick(half, b);
      rx = {rx[14:0], b};
    end
    repeat (half) @(posedge core_clk);
    cs_n <= 1'b1;
  endtask
endmodule

// file: test/touch_adc_serial_readout_tb_top.sv
`timescale 1ns/10ps
`include "touch_adc_consts.vh"
// Self-checking bench: APB register tasks plus host frames
module touch_adc_serial_readout_tb_top;
  logic        core_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [11:0] adc_sample;
  wire  [31:0] prdata;
  wire         pready, pslverr, sclk, cs_n, din, dout, dout_oe, busy;
  wire  [2:0]  channel_addr;
  wire         diff_mode, adc_power_on, ref_power_on;
  wire         dout_line = dout_oe ? dout : ~dout;  // Undriven line shows the inverse, so stale bits fail
  int          n_fail, total_checks;
  logic [7:0]  cw;
  logic [11:0] s;
  logic [15:0] rx;
  touch_adc_serial_readout dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_shift_clock(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe), .busy(busy),
    .adc_sample(adc_sample), .channel_addr(channel_addr), .diff_mode(diff_mode),
    .adc_power_on(adc_power_on), .ref_power_on(ref_power_on));
  host_port host (.core_clk(core_clk), .dout_line(dout_line), .serial_shift_clock(sclk), .cs_n(cs_n), .din(din));
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Counts a comparison, reports a mismatch
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Read with expected data and expected refusal
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
    chk({nm, " err"}, {31'h0, a[11:4] != 8'h00}, {31'h0, e});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // Verdict
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    conclude;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, adc_sample} = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdchk("ctrl", `OFS_CTRL, 32'h1);
    rdchk("status", `OFS_STATUS, 32'h0);
    rdchk("result", `OFS_RESULT, 32'h0);
    rdchk("count", `OFS_COUNT, 32'h0);
    rdchk("unmapped", 12'h010, 32'h0);
    wr(`OFS_RESULT, 32'hffff_ffff);
    rdchk("result ro", `OFS_RESULT, 32'h0);
    for (int i = 0; i < 4; i++) begin
      s = 12'ha5c ^ 12'(i * 12'h3c7);
      adc_sample <= s;
      cw = {1'b1, 3'(i * 3 + 1), i[0], i[1], i[1], i[0]};
      host.frame(cw, i, i[1] ? 10 : 6, i * 20, i[0] ? 12 : 16, rx);
      chk("rx", i[0] ? {20'h0, s[11:4], 4'h0} : {16'h0, s, 4'h0}, {16'h0, rx});
      chk("addr", {29'h0, cw[6:4]}, {29'h0, channel_addr});
      chk("diff", {31'h0, cw[2]}, {31'h0, diff_mode});
      chk("adc pwr mode", {31'h0, i[0]}, {31'h0, adc_power_on});
      chk("ref pwr mode", {31'h0, i[1]}, {31'h0, ref_power_on});
      repeat (6) @(posedge core_clk);
      rdchk("result", `OFS_RESULT, i[0] ? {20'h0, s[11:4], 4'h0} : {20'h0, s});
      rdchk("status", `OFS_STATUS, {16'h0, cw, 3'b000, i[1], 1'b0, 3'b000});
    end
    rdchk("count", `OFS_COUNT, 32'h4);
    host.frame(8'h80, 0, 6, 0, 3, rx);
    repeat (6) @(posedge core_clk);
    chk("adc pwr", 32'h0, {31'h0, adc_power_on});
    chk("ref pwr", 32'h1, {31'h0, ref_power_on});
    chk("oe", 32'h0, {31'h0, dout_oe});
    rdchk("aborts", `OFS_COUNT, 32'h0001_0004);
    wr(`OFS_CTRL, 32'h0);
    host.frame(8'h8f, 0, 6, 0, 16, rx);
    chk("disabled rx", 32'hffff, {16'h0, rx});
    rdchk("ctrl", `OFS_CTRL, 32'h0);
    rdchk("disabled", `OFS_COUNT, 32'h0001_0004);
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_COUNT, 32'h0);
    rdchk("cleared", `OFS_COUNT, 32'h0);
    // Repeated differential conversions on one channel, power down on the last
    for (int j = 0; j < 2; j++) begin
      cw = j ? 8'hd4 : 8'hd7;
      host.frame(cw, 0, 6, 0, 16, rx);
      chk("settle rx", {16'h0, s, 4'h0}, {16'h0, rx});
      chk("settle addr", 32'h5, {29'h0, channel_addr});
      chk("settle diff", 32'h1, {31'h0, diff_mode});
      chk("settle adc", {31'h0, j == 0}, {31'h0, adc_power_on});
      repeat (6) @(posedge core_clk);
    end
    rdchk("settled", `OFS_COUNT, 32'h2);
    conclude;
  end
endmodule
